// [core/wos_core.sv]
// Waveform output sequencer: sample queue, pacing, triggers, converter codes.
// Assumes all inputs are synchronous to clock; host obeys host_wr_ready.
`timescale 1ns/1ps
// What this block does
// (R1) Each sample clock drives codes, popping outside queue-only mode
// (R2) FIFO queue between host and converters
// (R3) Per-channel internal or external reference select
// (R4) Sixteen-bit code per converter channel
// (R5) Per-channel reglitch enable, cleared at reset
// (R6) One update per software command
// (R7) Hardware pacing, internal or external clock
// (R8) Host fills queue, device plays singly
// (R9) Finite mode stops after set count
// (R10) Continuous mode runs until stop
// (R11) Standard regeneration consumes host-refilled queue
// (R12) Queue-only replay, writes refused while running
// (R13) Non-regeneration flags underflow error
// (R14) Unbuffered samples go at next edge
// (R15) Start and pause hardware triggers
// (R16) One edge updates all, edge selectable
// (R17) Pause masks next samples, polarity selectable
// (R18) Start launches counter after configurable delay
// (R19) Empty queue: hold; without regeneration also flag, halt
// (R20) Queue-only read pointer wraps to first
module wos_core
  import wos_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic host_wr_valid,
  output logic host_wr_ready,
  input wire logic [wos_pkg::SAMPLE_W-1:0] host_wr_data,
  input wire wos_pkg::wos_timing_t timing_mode,
  input wire wos_pkg::wos_sample_t sample_mode,
  input wire wos_pkg::wos_regen_t regen_mode,
  input wire logic clock_source_external,
  input wire logic clock_edge_falling,
  input wire logic sample_update_clock,
  input wire logic [wos_pkg::PACE_W-1:0] pace_period,
  input wire logic [wos_pkg::PACE_W-1:0] begin_delay,
  input wire logic begin_trigger_enable,
  input wire logic generation_begin_trigger,
  input wire logic hold_trigger_enable,
  input wire logic hold_active_low,
  input wire logic generation_hold_trigger,
  input wire logic [wos_pkg::COUNT_W-1:0] finite_count,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic sw_update,
  input wire logic [wos_pkg::CHANNELS-1:0] reference_select_external,
  input wire logic [wos_pkg::CHANNELS-1:0] reglitch_select,
  input wire logic error_clear,
  output logic [wos_pkg::CODE_W-1:0] output_channel_zero,
  output logic [wos_pkg::CODE_W-1:0] output_channel_one,
  output logic converter_load,
  output logic [wos_pkg::CHANNELS-1:0] reference_external,
  output logic [wos_pkg::CHANNELS-1:0] reglitch_enable,
  output logic generation_running,
  output logic generation_done,
  output logic underflow_error,
  output logic [wos_pkg::LEVEL_W-1:0] queue_level,
  output logic sample_clock_out,
  output logic begin_trigger_out
);

  // Sequencer state
  wos_state_t state_reg;
  wos_state_t state_next;
  // Queue storage and pointers
  logic [SAMPLE_W-1:0] queue_mem [0:QUEUE_DEPTH-1];
  logic [QUEUE_AW-1:0] wr_ptr_reg;
  logic [QUEUE_AW-1:0] rd_ptr_reg;
  logic [LEVEL_W-1:0] count_reg;
  // Queue-only replay window
  logic [QUEUE_AW-1:0] base_reg;
  logic [LEVEL_W-1:0] loaded_reg;
  logic [QUEUE_AW-1:0] replay_idx_reg;
  // Finite sample tally
  logic [COUNT_W-1:0] sent_reg;
  // Edge detect history
  logic ext_clk_prev_reg;
  logic begin_trig_prev_reg;
  // Buffer to queue handshake
  logic buf_valid;
  logic buf_ready;
  // Buffer room before the queue-only lock is applied
  logic buf_in_ready;
  logic [SAMPLE_W-1:0] buf_data;
  // Event terms
  logic push;
  logic queue_only;
  logic locked;
  logic ext_edge;
  logic int_tick;
  logic pace_edge;
  logic paused;
  logic hw_update;
  logic update_req;
  logic avail;
  logic take;
  logic consume;
  logic underflow_hit;
  logic finite_hit;
  logic start_fire;
  logic stop_now;
  logic [QUEUE_AW-1:0] rd_addr;
  logic [SAMPLE_W-1:0] head_word;

  // Host words pass the two-entry buffer before the queue
  wos_pair_buf #(
    .WIDTH(SAMPLE_W)
  ) u_pair_buf (
    .clock(clock),
    .resetn(resetn),
    .in_valid(host_wr_valid && !locked),
    .in_ready(buf_in_ready),
    .in_data(host_wr_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // Internal sample clock counter
  wos_pace_gen u_pace_gen (
    .clock(clock),
    .resetn(resetn),
    .run(state_reg == WOS_RUN && !clock_source_external),
    .start(start_fire),
    .period(pace_period),
    .begin_delay(begin_delay),
    .tick(int_tick)
  );

  // Mode decode
  assign queue_only = (timing_mode == WOS_TIME_HW_BUFFERED) && (regen_mode == WOS_REGEN_QUEUE_ONLY);
  // No loading once a queue-only generation has left idle
  assign locked = queue_only && (state_reg != WOS_IDLE); // [R12]
  // Host sees an outright refusal while locked, not two more buffered words
  assign host_wr_ready = buf_in_ready && !locked; // [R12]
  // Queue accepts while not full and not locked; stall reaches host
  assign buf_ready = (count_reg != QUEUE_FULL_LEVEL) && !locked; // [R2] [R8]
  assign push = buf_valid & buf_ready;

  // External clock edge of the selected sense
  assign ext_edge = clock_edge_falling ? (ext_clk_prev_reg && !sample_update_clock)
                                       : (!ext_clk_prev_reg && sample_update_clock); // [R16]
  // Pacing from external pin or internal counter
  assign pace_edge = clock_source_external ? ext_edge : int_tick; // [R7]
  // Pause level sampled at the edge; in-progress update is unaffected
  assign paused = hold_trigger_enable && (generation_hold_trigger ^ hold_active_low); // [R17]
  assign hw_update = (timing_mode != WOS_TIME_SOFTWARE) && (state_reg == WOS_RUN) && pace_edge && !paused; // [R14]
  // Software mode: one command, one update
  assign update_req = hw_update || ((timing_mode == WOS_TIME_SOFTWARE) && sw_update); // [R6]

  // Data present for the next update
  assign avail = queue_only ? (loaded_reg != '0) : (count_reg != '0);
  assign take = update_req && avail; // [R1]
  // Queue-only replay keeps entries; other modes pop them
  assign consume = take && !queue_only; // [R11]
  assign rd_addr = queue_only ? (base_reg + replay_idx_reg) : rd_ptr_reg;
  assign head_word = queue_mem[rd_addr];

  // Starved non-regenerating generation is an error
  assign underflow_hit = hw_update && !avail && (timing_mode == WOS_TIME_HW_BUFFERED)
                         && (regen_mode == WOS_REGEN_NONE); // [R13] [R19]
  // Finite generation ends on the last counted sample
  assign finite_hit = take && (timing_mode == WOS_TIME_HW_BUFFERED) && (sample_mode == WOS_SAMPLE_FINITE)
                      && (sent_reg + 24'h000001 >= finite_count); // [R9]
  // Continuous runs end only by stop or error
  assign stop_now = sw_stop || underflow_hit || finite_hit; // [R10]

  // Start: immediately, or at begin trigger rising edge
  always_comb
  begin
    state_next = state_reg;
    start_fire = 1'b0;
    unique case (state_reg)
      // Waiting for software start
      WOS_IDLE:
      begin
        if (sw_start && timing_mode != WOS_TIME_SOFTWARE)
        begin
          if (begin_trigger_enable)
            state_next = WOS_ARMED;
          else
          begin
            state_next = WOS_RUN;
            start_fire = 1'b1;
          end
        end
      end
      // Waiting for the hardware begin trigger
      WOS_ARMED:
      begin
        if (sw_stop)
          state_next = WOS_IDLE;
        else if (generation_begin_trigger && !begin_trig_prev_reg)
        begin
          state_next = WOS_RUN; // [R15]
          start_fire = 1'b1; // [R18]
        end
      end
      // Generating
      WOS_RUN:
      begin
        if (stop_now)
          state_next = WOS_IDLE;
      end
      default:
        state_next = WOS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      state_reg <= WOS_IDLE;
    else
      state_reg <= state_next;
  end

  // Edge detect history
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_clk_prev_reg <= 1'b0;
      begin_trig_prev_reg <= 1'b0;
    end
    else
    begin
      ext_clk_prev_reg <= sample_update_clock;
      begin_trig_prev_reg <= generation_begin_trigger;
    end
  end

  // Queue storage write
  always_ff @(posedge clock)
  begin
    if (push)
      queue_mem[wr_ptr_reg] <= buf_data; // [R2]
  end

  // Queue pointers and level
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 6'h01;
      if (consume)
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
      if (push && !consume)
        count_reg <= count_reg + 7'h01;
      else if (consume && !push)
        count_reg <= count_reg - 7'h01;
    end
  end

  // Queue-only window captured as the generation leaves idle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      base_reg <= '0;
      loaded_reg <= '0;
      replay_idx_reg <= '0;
    end
    else if (state_reg == WOS_IDLE && state_next != WOS_IDLE)
    begin
      base_reg <= rd_ptr_reg;
      loaded_reg <= count_reg + {6'h00, push};
      replay_idx_reg <= '0;
    end
    else if (take && queue_only)
    begin
      // Back to the first loaded sample after the last
      if ({1'b0, replay_idx_reg} + 7'h01 >= loaded_reg)
        replay_idx_reg <= '0; // [R20]
      else
        replay_idx_reg <= replay_idx_reg + 6'h01;
    end
  end

  // Samples sent in this generation
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sent_reg <= '0;
    else if (start_fire)
      sent_reg <= '0;
    else if (take)
      sent_reg <= sent_reg + 24'h000001;
  end

  // Converter codes, all channels at once; held when no data
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      output_channel_zero <= '0;
      output_channel_one <= '0;
      converter_load <= 1'b0;
    end
    else
    begin
      converter_load <= take; // [R16]
      if (take)
      begin
        output_channel_zero <= head_word[CH0_LSB +: CODE_W]; // [R1] [R4]
        output_channel_one <= head_word[CH1_LSB +: CODE_W]; // [R4]
      end
    end
  end

  // Per-channel analog settings
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      reference_external <= REF_SELECT_RESET;
      reglitch_enable <= REGLITCH_RESET;
    end
    else
    begin
      reference_external <= reference_select_external; // [R3]
      reglitch_enable <= reglitch_select; // [R5]
    end
  end

  // Underflow flag; a new underflow beats a clear
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      underflow_error <= 1'b0;
    else if (underflow_hit)
      underflow_error <= 1'b1; // [R19]
    else if (error_clear)
      underflow_error <= 1'b0;
  end

  // Status and event outputs
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      generation_running <= 1'b0;
      generation_done <= 1'b0;
      queue_level <= '0;
      sample_clock_out <= 1'b0;
      begin_trigger_out <= 1'b0;
    end
    else
    begin
      generation_running <= (state_next == WOS_RUN);
      generation_done <= (state_reg == WOS_RUN) && finite_hit; // [R9]
      queue_level <= count_reg;
      sample_clock_out <= hw_update;
      begin_trigger_out <= start_fire;
    end
  end

endmodule // wos_core

// [shared/wos_pkg.sv]
// Shared constants and mode types for the waveform output sequencer.
// Assumes one 50 MHz system clock; all users import the whole package.
package wos_pkg;

  // System clock rate
  localparam int unsigned CLOCK_HZ = 50_000_000;

  // Output channels and converter code width
  localparam int unsigned CHANNELS = 2;
  localparam int unsigned CODE_W = 16;
  // Code steps over the selected range: one step is range / CODE_STEPS
  localparam int unsigned CODE_STEPS = 65536;
  // One queue entry carries one code per channel, channel zero low
  localparam int unsigned SAMPLE_W = 32;
  localparam int unsigned CH0_LSB = 0;
  localparam int unsigned CH1_LSB = 16;

  // Internal reference level in volts
  localparam int unsigned INTERNAL_REF_VOLTS = 10;

  // Onboard sample queue geometry
  localparam int unsigned QUEUE_DEPTH = 64;
  localparam int unsigned QUEUE_AW = 6;
  localparam int unsigned LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] QUEUE_FULL_LEVEL = 7'h40;

  // Finite sample count and pacing counter widths
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned PACE_W = 16;
  // Begin trigger to first sample clock, in timebase ticks
  localparam logic [PACE_W-1:0] DEFAULT_BEGIN_DELAY = 16'h0002;

  // Reset values of the per-channel settings
  localparam logic [CHANNELS-1:0] REF_SELECT_RESET = 2'h0;
  localparam logic [CHANNELS-1:0] REGLITCH_RESET = 2'h0;

  // How conversions are paced
  typedef enum logic [1:0] {
    WOS_TIME_SOFTWARE = 2'b00,
    WOS_TIME_HW_UNBUFFERED = 2'b01,
    WOS_TIME_HW_BUFFERED = 2'b10
  } wos_timing_t;

  // Finite or continuous generation
  typedef enum logic {
    WOS_SAMPLE_FINITE = 1'b0,
    WOS_SAMPLE_CONTINUOUS = 1'b1
  } wos_sample_t;

  // What data is replayed
  typedef enum logic [1:0] {
    WOS_REGEN_STANDARD = 2'b00,
    WOS_REGEN_QUEUE_ONLY = 2'b01,
    WOS_REGEN_NONE = 2'b10
  } wos_regen_t;

  // Generation sequencer states
  typedef enum logic [1:0] {
    WOS_IDLE = 2'b00,
    WOS_ARMED = 2'b01,
    WOS_RUN = 2'b10
  } wos_state_t;

endpackage

// [core/wos_pair_buf.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides share the system clock; a stalled drain loses no word.
`timescale 1ns/1ps
module wos_pair_buf #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // Two storage slots, slot zero is the head
  logic [WIDTH-1:0] slot0_reg;
  logic [WIDTH-1:0] slot1_reg;
  // Number of words held
  logic [1:0] fill_reg;
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = (fill_reg != 2'h2);
  assign out_valid = (fill_reg != 2'h0);
  assign out_data = slot0_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Fill level
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      fill_reg <= 2'h0;
    else if (push && !pop)
      fill_reg <= fill_reg + 2'h1;
    else if (pop && !push)
      fill_reg <= fill_reg - 2'h1;
  end

  // Slot data movement
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      slot0_reg <= '0;
      slot1_reg <= '0;
    end
    else
    begin
      // Head advances on a pop
      if (pop)
        slot0_reg <= (fill_reg == 2'h2) ? slot1_reg : in_data;
      else if (push && fill_reg == 2'h0)
        slot0_reg <= in_data;
      // Second slot fills when head stays occupied
      if (push && ((fill_reg == 2'h1 && !pop) || (fill_reg == 2'h2)))
        slot1_reg <= in_data;
    end
  end

endmodule // wos_pair_buf

// [core/wos_pace_gen.sv]
// Internal sample clock generator: start delay, then one tick per period.
// Assumes the system clock serves as the timebase tick.
`timescale 1ns/1ps
module wos_pace_gen
  import wos_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic run,
  input wire logic start,
  input wire logic [wos_pkg::PACE_W-1:0] period,
  input wire logic [wos_pkg::PACE_W-1:0] begin_delay,
  output logic tick
);

  // Down counter to the next tick
  logic [PACE_W-1:0] count_reg;
  logic [PACE_W-1:0] delay_eff;
  logic [PACE_W-1:0] period_eff;

  // Zero delay selects the default two ticks
  assign delay_eff = (begin_delay == '0) ? DEFAULT_BEGIN_DELAY : begin_delay;
  // A period below one cycle is taken as one
  assign period_eff = (period == '0) ? 16'h0001 : period;
  assign tick = run & !start & (count_reg == 16'h0001);

  // Load the delay on start, reload the period on each tick
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      count_reg <= '0;
    else if (start)
      count_reg <= delay_eff;
    else if (!run)
      count_reg <= '0;
    else if (count_reg == 16'h0001)
      count_reg <= period_eff;
    else if (count_reg != '0)
      count_reg <= count_reg - 16'h0001;
  end

endmodule // wos_pace_gen

// [tb/wos_core_monitor.sv]
// Port checker for the waveform output sequencer core.
// Assumes one clock domain; bound to wos_core from the testbench.
`timescale 1ns/1ps
module wos_core_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire wos_pkg::wos_timing_t timing_mode,
  input wire logic hold_trigger_enable,
  input wire logic hold_active_low,
  input wire logic generation_hold_trigger,
  input wire logic sw_update,
  input wire logic error_clear,
  input wire logic [1:0] reference_select_external,
  input wire logic [1:0] reglitch_select,
  input wire logic [15:0] output_channel_zero,
  input wire logic [15:0] output_channel_one,
  input wire logic converter_load,
  input wire logic [1:0] reference_external,
  input wire logic [1:0] reglitch_enable,
  input wire logic generation_running,
  input wire logic generation_done,
  input wire logic underflow_error,
  input wire logic sample_clock_out,
  input wire logic begin_trigger_out
);
  import wos_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Launch: running rises together with the marker
  sequence s_launch;
    $rose(generation_running) ##0 begin_trigger_out;
  endsequence
  // Update edge masked by the hold trigger
  sequence s_paused;
    hold_trigger_enable && (generation_hold_trigger != hold_active_low) && (timing_mode != WOS_TIME_SOFTWARE);
  endsequence
  chk_reset_clear: assert property ($rose(resetn) |-> reglitch_enable == REGLITCH_RESET
    && reference_external == REF_SELECT_RESET && !generation_running) else $error("settings not clear after reset");
  chk_channel_settings: assert property ($past(resetn) |-> reference_external == $past(reference_select_external)
    && reglitch_enable == $past(reglitch_select)) else $error("channel settings not followed");
  chk_codes_held: assert property (!converter_load |-> $stable(output_channel_zero)
    && $stable(output_channel_one)) else $error("codes changed without load");
  chk_done_stops: assert property (generation_done |-> !generation_running
    && $past(generation_running)) else $error("done without stop");
  chk_underflow_halts: assert property ($rose(underflow_error) |-> !generation_running)
    else $error("running after underflow");
  chk_underflow_sticky: assert property (underflow_error && !error_clear |=> underflow_error)
    else $error("underflow flag lost");
  chk_pause_masks: assert property (s_paused |=> !sample_clock_out)
    else $error("update while paused");
  chk_sw_one_update: assert property (converter_load && timing_mode == WOS_TIME_SOFTWARE
    && $past(timing_mode) == WOS_TIME_SOFTWARE |-> $past(sw_update)) else $error("unasked update");
  chk_launch_marker: assert property (begin_trigger_out |-> s_launch)
    else $error("marker without launch");
endmodule // wos_core_monitor

// [tb/wos_host_model.sv]
// Host model: offers queued words as DMA-style writes.
// Assumes the core's combinational host_wr_ready.
`timescale 1ns/1ps
module wos_host_model (
  input wire logic clock,
  input wire logic slow,
  output logic host_wr_valid,
  input wire logic host_wr_ready,
  output logic [31:0] host_wr_data
);
  logic [31:0] pend[$]; // Words still to send
  logic took = 1'b0; // Word taken at last edge
  initial host_wr_valid = 1'b0;
  initial host_wr_data = 32'h0;
  // Queue one word; blocks stay within the queue depth
  task automatic push(input logic [31:0] w);
    pend.push_back(w);
  endtask
  // Taken when ready seen high at the edge
  always @(posedge clock)
    took <= host_wr_valid & host_wr_ready;
  // Hold an offer until taken; slow adds a gap; released data toggles
  always @(negedge clock)
  begin
    if (took)
      pend.delete(0);
    if (!host_wr_valid || took)
    begin
      host_wr_valid = pend.size() > 0 && !(slow && took);
      host_wr_data = host_wr_valid ? pend[0] : ~host_wr_data;
    end
  end
endmodule // wos_host_model

// [tb/testbench.sv]
// Self-checking bench for the waveform output sequencer core.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
module testbench;
  import wos_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, slow = 1'b0;
  logic host_wr_valid, host_wr_ready;
  logic [31:0] host_wr_data;
  wos_timing_t timing_mode = WOS_TIME_SOFTWARE;
  wos_sample_t sample_mode = WOS_SAMPLE_FINITE;
  wos_regen_t regen_mode = WOS_REGEN_STANDARD;
  logic clock_source_external = 1'b0, clock_edge_falling = 1'b0, sample_update_clock = 1'b0;
  logic begin_trigger_enable = 1'b0, generation_begin_trigger = 1'b0, hold_trigger_enable = 1'b0;
  logic hold_active_low = 1'b0, generation_hold_trigger = 1'b0, error_clear = 1'b0;
  logic sw_start = 1'b0, sw_stop = 1'b0, sw_update = 1'b0;
  logic [15:0] pace_period = 16'h0004, begin_delay = 16'h0000, output_channel_zero, output_channel_one;
  logic [23:0] finite_count = 24'h000003;
  logic [1:0] reference_select_external = 2'h0, reglitch_select = 2'h0, reference_external, reglitch_enable;
  logic converter_load, generation_running, generation_done, underflow_error, sample_clock_out, begin_trigger_out;
  logic [6:0] queue_level;
  logic [31:0] seen[$]; // Codes at each update
  int loads = 0, dones = 0, mismatches = 0, checked = 0, lat[2], n;
  wos_core wos_core_inst (.clock, .resetn, .host_wr_valid, .host_wr_ready, .host_wr_data, .timing_mode,
    .sample_mode, .regen_mode, .clock_source_external, .clock_edge_falling, .sample_update_clock, .pace_period,
    .begin_delay, .begin_trigger_enable, .generation_begin_trigger, .hold_trigger_enable, .hold_active_low,
    .generation_hold_trigger, .finite_count, .sw_start, .sw_stop, .sw_update, .reference_select_external,
    .reglitch_select, .error_clear, .output_channel_zero, .output_channel_one, .converter_load,
    .reference_external, .reglitch_enable, .generation_running, .generation_done, .underflow_error,
    .queue_level, .sample_clock_out, .begin_trigger_out);
  wos_host_model wos_host_model_inst (.clock, .slow, .host_wr_valid, .host_wr_ready, .host_wr_data);
  // 20 ns clock
  always #10 clock = ~clock;
  // Record updates once the edge has settled
  always @(posedge clock)
  begin
    #2;
    loads += (converter_load === 1'b1);
    dones += (generation_done === 1'b1);
    if (converter_load === 1'b1)
      seen.push_back({output_channel_one, output_channel_zero});
  end
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  // One-cycle command: 0 start, 1 stop, 2 update, 3 clear
  task automatic pulse(input int k);
    {error_clear, sw_update, sw_stop, sw_start} = 4'h1 << k;
    tick(1);
    {error_clear, sw_update, sw_stop, sw_start} = 4'h0;
  endtask
  task automatic put(input logic [31:0] w);
    wos_host_model_inst.push(w);
  endtask
  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
    checked++;
    if (got !== expv)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic do_reset();
    resetn = 1'b0;
    tick(8);
    seen.delete();
    loads = 0;
    dones = 0;
    resetn = 1'b1;
    tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog over the whole run
  initial
  begin
    repeat (5000) @(posedge clock);
    mismatches++;
    finish_test();
  end
  initial
  begin
    do_reset();
    check("reglitch reset", 32'h0, reglitch_enable);
    reference_select_external = 2'h2;
    reglitch_select = 2'h1;
    put(32'h1234_8001);
    put(32'hFFFF_0000);
    tick(6);
    check("ref per channel", 32'h2, reference_external);
    check("reglitch per channel", 32'h1, reglitch_enable);
    check("no unasked update", 32'h0, loads);
    check("queue level", 32'h2, queue_level);
    pulse(2);
    tick(2);
    check("ch0 code", 32'h8001, output_channel_zero);
    check("ch1 code", 32'h1234, output_channel_one);
    pulse(2);
    tick(2);
    check("one per command", 32'h2, loads);
    check("queue order", 32'hFFFF_0000, seen[1]);
    // Finite paced runs at default and long start delay
    timing_mode = WOS_TIME_HW_BUFFERED;
    for (int i = 0; i < 2; i++)
    begin
      begin_delay = i ? 16'h000A : 16'h0000;
      slow = (i == 1);
      do_reset();
      for (int k = 0; k < 3; k++)
        put(32'hA000_0100 + k);
      tick(10);
      pulse(0);
      n = 0;
      while (loads == 0 && n < 60)
      begin
        tick(1);
        n++;
      end
      lat[i] = n;
      tick(4);
      check("pace period", 32'h2, loads);
      tick(10);
      check("stops at count", 32'h3, loads);
      check("done once", 32'h1, dones);
      check("stopped", 32'h0, generation_running);
      for (int k = 0; k < 3; k++)
        check("played word", 32'hA000_0100 + k, seen[k]);
    end
    check("start delay", 32'h8, lat[1] - lat[0]);
    // Low-level pause holds updates
    sample_mode = WOS_SAMPLE_CONTINUOUS;
    hold_trigger_enable = 1'b1;
    hold_active_low = 1'b1;
    do_reset();
    put(32'h5555_AAAA);
    tick(6);
    pulse(0);
    tick(20);
    check("paused", 32'h0, loads);
    check("running", 32'h1, generation_running);
    generation_hold_trigger = 1'b1;
    tick(8);
    check("resumed", 32'h5555_AAAA, seen[0]);
    pulse(1);
    hold_trigger_enable = 1'b0;
    // Empty queue without regeneration
    regen_mode = WOS_REGEN_NONE;
    do_reset();
    pulse(0);
    tick(12);
    check("underflow", 32'h1, underflow_error);
    check("halted", 32'h0, generation_running);
    pulse(3);
    tick(2);
    check("cleared", 32'h0, underflow_error);
    // External pin, falling edge, unbuffered
    timing_mode = WOS_TIME_HW_UNBUFFERED;
    regen_mode = WOS_REGEN_STANDARD;
    clock_source_external = 1'b1;
    clock_edge_falling = 1'b1;
    do_reset();
    put(32'h0F0F_7FFF);
    tick(6);
    pulse(0);
    sample_update_clock = 1'b1;
    tick(6);
    check("rising ignored", 32'h0, loads);
    sample_update_clock = 1'b0;
    tick(4);
    check("falling update", 32'h0F0F_7FFF, seen[0]);
    check("one update", 32'h1, loads);
    // Queue-only replay started by the begin trigger
    timing_mode = WOS_TIME_HW_BUFFERED;
    regen_mode = WOS_REGEN_QUEUE_ONLY;
    clock_source_external = 1'b0;
    begin_trigger_enable = 1'b1;
    do_reset();
    put(32'h1111_2222);
    put(32'h3333_4444);
    tick(8);
    pulse(0);
    tick(4);
    check("armed waits", 32'h0, generation_running);
    generation_begin_trigger = 1'b1;
    tick(3);
    check("trigger starts", 32'h1, generation_running);
    check("writes refused", 32'h0, host_wr_ready);
    tick(20);
    for (int k = 0; k < 4; k++)
      check("replay wrap", k[0] ? 32'h3333_4444 : 32'h1111_2222, seen[k]);
    finish_test();
  end
endmodule // testbench
bind wos_core wos_core_monitor wos_core_monitor_inst (.clock, .resetn, .timing_mode, .hold_trigger_enable,
  .hold_active_low, .generation_hold_trigger, .sw_update, .error_clear, .reference_select_external,
  .reglitch_select, .output_channel_zero, .output_channel_one, .converter_load, .reference_external,
  .reglitch_enable, .generation_running, .generation_done, .underflow_error, .sample_clock_out,
  .begin_trigger_out);
